// [scp_cfg.svh]
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define SCP_ADDR_CFG_A     15'h0000
`define SCP_ADDR_CFG_B     15'h0001
`define SCP_ADDR_PWR       15'h0002
`define SCP_ADDR_STEP      15'h0001

// ***************************************************************
// Field positions and reset values
// ***************************************************************
`define SCP_A_SOFT_RST     0
`define SCP_A_LSB_FIRST    1
`define SCP_A_ASCEND       2
`define SCP_B_DP_RST       1
`define SCP_B_SINGLE       7
`define SCP_PWR_LO         0
`define SCP_PWR_HI         1
`define SCP_RST_BIT        1'h0
`define SCP_RST_PWR        2'h0
`define SCP_RST_OE_N       1'h1
`define SCP_RST_PWR_CTL    4'hB
`define SCP_BYTE_ZERO      8'h00

// ***************************************************************
// Power mode codes
// ***************************************************************
`define SCP_PWR_NORMAL     2'h0
`define SCP_PWR_UNSUP      2'h1
`define SCP_PWR_STANDBY    2'h2
`define SCP_PWR_DOWN       2'h3

// ***************************************************************
// Serial frame layout
// ***************************************************************
`define SCP_INSTR_RD       15
`define SCP_INSTR_LAST     4'hF
`define SCP_BYTE_LAST      3'h7
`define SCP_INSTR_ONE      16'h0001
`define SCP_BYTE_ONE       8'h01

// ***************************************************************
// Boot wait after full soft reset (kept by the host)
// ***************************************************************
`define SCP_CLK_HZ         10000000
`define SCP_BOOT_WAIT_MS   5
`define SCP_BOOT_WAIT_CYC  (`SCP_BOOT_WAIT_MS * (`SCP_CLK_HZ / 1000))

`endif

// [scp_pkg.sv]
package scp_pkg;

   typedef enum logic [1:0] {
      ST_INSTR,
      ST_DATA,
      ST_HOLD
   } scp_state_e;

   typedef struct packed {
      logic clk_en;
      logic dp_rst;
      logic link_en;
      logic out_en;
   } scp_pwr_s;

endpackage : scp_pkg

// [scp_regs.sv]
// Functional notes
// - Multibyte transfers always auto-increment the address, whatever the ascension bit holds.
// - Config A bit 1 set shifts every byte LSB first; clear shifts MSB first.
// - Writing 1 to config A bit 0 resets interface and registers; self-clearing.
// - Config B bit 7 set allows one read or write per select assertion.
// - Writing 1 to config B bit 1 pulses datapath reset; bit self-clears.
// - Power mode 00 is normal, fully powered; it is the reset value.
// - Power mode 10 is standby: datapath clocks off, link and outputs on.
// - Power mode 11 is power-down: clocks off, datapath reset, link and outputs off.
`timescale 1ns/1ps
`include "scp_cfg.svh"

module scp_regs (
   input  wire logic             clk,                  // 10 MHz system clock
   input  wire logic             rst,                  // Synchronous reset, active high
   input  wire logic             sclk,                 // Serial clock, sampled
   input  wire logic             serial_select_line_n, // Serial select, active low
   input  wire logic             sdi,                  // Serial data in
   output logic                  sdo,                  // Serial data out
   output logic                  sdo_oe_n,             // Serial data out enable, active low
   output scp_pkg::scp_pwr_s     pwr,                  // Datapath power controls
   output logic                  dp_soft_rst           // Datapath soft reset pulse
);

   // ***************************************************************
   // Registers
   // ***************************************************************
   scp_pkg::scp_state_e state_ff;
   scp_pkg::scp_state_e nxt_state;
   logic                sclk_q_ff;
   logic [3:0]          icnt_ff;
   logic [2:0]          bcnt_ff;
   logic [15:0]         instr_ff;
   logic [7:0]          rx_ff;
   logic [7:0]          tx_ff;
   logic [14:0]         addr_ff;
   logic                ascend_ff;
   logic                lsb_first_ff;
   logic                single_ff;
   logic [1:0]          pwr_mode_ff;
   logic                soft_rst_ff;
   logic                dp_rst_pulse_ff;
   logic                sdo_ff;
   logic                sdo_oe_n_ff;
   scp_pkg::scp_pwr_s   pwr_ff;

   // ***************************************************************
   // Serial edge decode
   // ***************************************************************
   wire        sel       = ~serial_select_line_n;
   wire        rise      = sel & sclk & ~sclk_q_ff;
   wire        fall      = sel & ~sclk & sclk_q_ff;
   wire [3:0]  ipos      = lsb_first_ff ? icnt_ff : (`SCP_INSTR_LAST - icnt_ff);
   wire [2:0]  bpos      = lsb_first_ff ? bcnt_ff : (`SCP_BYTE_LAST - bcnt_ff);
   wire [15:0] imask     = `SCP_INSTR_ONE << ipos;
   wire [7:0]  bmask     = `SCP_BYTE_ONE << bpos;
   wire [15:0] nxt_instr = sdi ? (instr_ff | imask) : (instr_ff & ~imask);
   wire [7:0]  nxt_rx    = sdi ? (rx_ff | bmask) : (rx_ff & ~bmask);
   wire        in_instr  = (state_ff == scp_pkg::ST_INSTR);
   wire        in_data   = (state_ff == scp_pkg::ST_DATA);
   wire        instr_end = rise & in_instr & (icnt_ff == `SCP_INSTR_LAST);
   wire        byte_end  = rise & in_data & (bcnt_ff == `SCP_BYTE_LAST);
   wire        is_read   = instr_ff[`SCP_INSTR_RD];
   wire        wr_fire   = byte_end & ~is_read;

   // ***************************************************************
   // Address and read data
   // ***************************************************************
   wire [14:0] instr_addr = nxt_instr[14:0];
   wire [14:0] next_addr  = addr_ff + `SCP_ADDR_STEP;
   wire [14:0] load_addr  = instr_end ? instr_addr : next_addr;

   // Self-clearing and reserved bits always read zero
   wire [7:0] rd_cfg_a = (`SCP_BYTE_ONE << `SCP_A_ASCEND) & {8{ascend_ff}}
                       | (`SCP_BYTE_ONE << `SCP_A_LSB_FIRST) & {8{lsb_first_ff}};
   wire [7:0] rd_cfg_b = (`SCP_BYTE_ONE << `SCP_B_SINGLE) & {8{single_ff}};
   wire [7:0] rd_pwr   = {6'h00, pwr_mode_ff};
   wire [7:0] rd_data  = (load_addr == `SCP_ADDR_CFG_A) ? rd_cfg_a :
                         (load_addr == `SCP_ADDR_CFG_B) ? rd_cfg_b :
                         (load_addr == `SCP_ADDR_PWR)   ? rd_pwr   : `SCP_BYTE_ZERO;

   // ***************************************************************
   // Register write decode
   // ***************************************************************
   wire wr_a      = wr_fire & (addr_ff == `SCP_ADDR_CFG_A);
   wire wr_b      = wr_fire & (addr_ff == `SCP_ADDR_CFG_B);
   wire wr_p      = wr_fire & (addr_ff == `SCP_ADDR_PWR);
   wire [1:0] wr_mode  = nxt_rx[`SCP_PWR_HI:`SCP_PWR_LO];
   wire       mode_ok  = (wr_mode != `SCP_PWR_UNSUP);
   wire [1:0] nxt_mode = (wr_p & mode_ok) ? wr_mode : pwr_mode_ff;
   wire       full_rst = rst | soft_rst_ff;

   // ***************************************************************
   // Power control decode
   // ***************************************************************
   wire mode_sb   = (nxt_mode == `SCP_PWR_STANDBY);
   wire mode_pd   = (nxt_mode == `SCP_PWR_DOWN);
   wire nxt_dprst = mode_pd | (wr_b & nxt_rx[`SCP_B_DP_RST]);
   scp_pkg::scp_pwr_s nxt_pwr;
   assign nxt_pwr.clk_en  = ~(mode_sb | mode_pd);
   assign nxt_pwr.dp_rst  = nxt_dprst;
   assign nxt_pwr.link_en = ~mode_pd;
   assign nxt_pwr.out_en  = ~mode_pd;

   // ***************************************************************
   // Transfer sequencer
   // ***************************************************************
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         scp_pkg::ST_INSTR: begin
            if (instr_end) begin
               nxt_state = scp_pkg::ST_DATA;
            end
         end
         scp_pkg::ST_DATA: begin
            if (byte_end & single_ff) begin
               nxt_state = scp_pkg::ST_HOLD;
            end
         end
         scp_pkg::ST_HOLD: begin
            nxt_state = scp_pkg::ST_HOLD;
         end
         default: begin
            nxt_state = scp_pkg::ST_INSTR;
         end
      endcase
      if (!sel) begin
         nxt_state = scp_pkg::ST_INSTR;
      end
      if (wr_a & nxt_rx[`SCP_A_SOFT_RST]) begin
         nxt_state = scp_pkg::ST_HOLD;
      end
   end

   always_ff @(posedge clk) begin
      if (full_rst) begin
         state_ff <= scp_pkg::ST_INSTR;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_q_ff <= `SCP_RST_BIT;
      end else begin
         sclk_q_ff <= sclk;
      end
   end

   always_ff @(posedge clk) begin
      if (full_rst | !sel) begin
         icnt_ff  <= '0;
         bcnt_ff  <= '0;
         instr_ff <= '0;
         rx_ff    <= `SCP_BYTE_ZERO;
      end else if (rise & in_instr) begin
         icnt_ff  <= icnt_ff + 4'h1;
         instr_ff <= nxt_instr;
      end else if (rise & in_data) begin
         bcnt_ff  <= bcnt_ff + 3'h1;
         rx_ff    <= byte_end ? `SCP_BYTE_ZERO : nxt_rx;
      end
   end

   always_ff @(posedge clk) begin
      if (full_rst) begin
         addr_ff <= '0;
         tx_ff   <= `SCP_BYTE_ZERO;
      end else if (instr_end | byte_end) begin
         addr_ff <= load_addr;
         tx_ff   <= rd_data;
      end
   end

   // ***************************************************************
   // Serial output
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (full_rst) begin
         sdo_ff      <= `SCP_RST_BIT;
         sdo_oe_n_ff <= `SCP_RST_OE_N;
      end else begin
         sdo_oe_n_ff <= ~(sel & in_data & is_read);
         if (fall & in_data) begin
            sdo_ff <= tx_ff[bpos];
         end
      end
   end

   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (full_rst) begin
         ascend_ff    <= `SCP_RST_BIT;
         lsb_first_ff <= `SCP_RST_BIT;
         single_ff    <= `SCP_RST_BIT;
         pwr_mode_ff  <= `SCP_RST_PWR;
      end else begin
         if (wr_a) begin
            ascend_ff    <= nxt_rx[`SCP_A_ASCEND];
            lsb_first_ff <= nxt_rx[`SCP_A_LSB_FIRST];
         end
         if (wr_b) begin
            single_ff <= nxt_rx[`SCP_B_SINGLE];
         end
         pwr_mode_ff <= nxt_mode;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         soft_rst_ff <= `SCP_RST_BIT;
      end else begin
         soft_rst_ff <= wr_a & nxt_rx[`SCP_A_SOFT_RST];
      end
   end

   always_ff @(posedge clk) begin
      if (full_rst) begin
         dp_rst_pulse_ff <= `SCP_RST_BIT;
         pwr_ff          <= `SCP_RST_PWR_CTL;
      end else begin
         dp_rst_pulse_ff <= wr_b & nxt_rx[`SCP_B_DP_RST];
         pwr_ff          <= nxt_pwr;
      end
   end

   assign sdo         = sdo_ff;
   assign sdo_oe_n    = sdo_oe_n_ff;
   assign pwr         = pwr_ff;
   assign dp_soft_rst = dp_rst_pulse_ff;

endmodule : scp_regs

// [scp_regs_chk.sv]
`timescale 1ns/1ps
module scp_regs_chk (
   input  wire logic        clk,                  // Clock
   input  wire logic        rst,                  // Synchronous reset
   input  wire logic        serial_select_line_n, // Select, active low
   input  wire logic        sdo_oe_n,             // Data out enable, active low
   input  scp_pkg::scp_pwr_s pwr,                 // Power controls
   input  wire logic        dp_soft_rst           // Datapath reset pulse
);
   // ******************************
   // Power and reset relations
   // ******************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   rst_vals_a: assert property (disable iff (1'h0) rst |=> pwr == 4'hB && sdo_oe_n && !dp_soft_rst)
      else $error("reset values wrong");
   pwr_code_a: assert property (pwr inside {4'hB, 4'h3, 4'h4, 4'hF, 4'h7})
      else $error("illegal power control pattern");
   stby_out_a: assert property (!pwr.clk_en && pwr.link_en |-> pwr.out_en && !pwr.dp_rst)
      else $error("standby controls wrong");
   down_ctl_a: assert property (pwr.dp_rst && !dp_soft_rst |-> !pwr.clk_en && !pwr.link_en && !pwr.out_en)
      else $error("power-down controls wrong");
   dp_pulse_a: assert property (dp_soft_rst |=> !dp_soft_rst)
      else $error("datapath reset pulse too long");
   dp_join_a: assert property (dp_soft_rst |-> pwr.dp_rst)
      else $error("datapath reset not on power control");
   oe_idle_a: assert property (serial_select_line_n && $past(serial_select_line_n) |-> sdo_oe_n)
      else $error("data out driven while deselected");
   pwr_hold_a: assert property (serial_select_line_n [*2] |=> $stable(pwr))
      else $error("power mode changed while idle");
   cover property (dp_soft_rst);
   cover property (pwr == 4'h3);
   cover property (pwr == 4'h4);
   cover property (!sdo_oe_n);
endmodule : scp_regs_chk

bind scp_regs scp_regs_chk u_chk (.clk(clk), .rst(rst), .serial_select_line_n(serial_select_line_n),
   .sdo_oe_n(sdo_oe_n), .pwr(pwr), .dp_soft_rst(dp_soft_rst));

// [scp_host.sv]
`timescale 1ns/1ps
module scp_host (
   input  wire logic clk,                  // Clock
   input  wire logic sdo,                  // Serial data from device
   output logic      sclk,                 // Serial clock, still outside frames
   output logic      serial_select_line_n, // Select, active low
   output logic      sdi                   // Serial data to device
);
   initial begin
      sclk = 1'h0;
      serial_select_line_n = 1'h1;
      sdi = 1'h0;
   end
   // Two clocks low, then high; sdo is taken just before the rise
   task automatic shift(input logic [15:0] v, input int w, input logic lsb, output logic [15:0] r);
      int k;
      r = 16'h0000;
      for (int i = 0; i < w; i++) begin
         k = lsb ? i : w - 1 - i;
         @(negedge clk) sdi <= v[k];
         sclk <= 1'h0;
         repeat (2) @(negedge clk);
         r[k] = sdo;
         sclk <= 1'h1;
         repeat (2) @(negedge clk);
      end
   endtask : shift
   task automatic frame(input logic rw, input logic [14:0] a, input logic lsb, input int nb,
                        input logic [15:0] wd, output logic [15:0] rv);
      logic [15:0] r;
      rv = 16'h0000;
      @(negedge clk) serial_select_line_n <= 1'h0;
      shift({rw, a}, 16, lsb, r);
      for (int b = 0; b < nb; b++) begin
         shift({8'h00, wd[b*8+:8]}, 8, lsb, r);
         rv[b*8+:8] = r[7:0];
      end
      @(negedge clk) sclk <= 1'h0;
      sdi <= ~sdi;
      @(negedge clk) serial_select_line_n <= 1'h1;
      repeat (2) @(negedge clk);
   endtask : frame
endmodule : scp_host

// [testbench.sv]
`timescale 1ns/1ps
`include "scp_cfg.svh"
module testbench;
   typedef struct packed {logic [7:0] wd; logic [3:0] pw; logic [7:0] rb;} scp_row_s;
   logic              clk = 1'h0;
   logic              rst = 1'h1;
   logic              sclk, serial_select_line_n, sdi, sdo, sdo_oe_n, dp_soft_rst;
   scp_pkg::scp_pwr_s pwr;
   int                fail_count = 0;
   int                compares = 0;
   int                dp_cnt = 0;
   logic [15:0]       rv;
   // Reserved bits set in every write; code 01 must be ignored
   scp_row_s rows [4] = '{'{8'hFE, 4'h3, 8'h02}, '{8'hFD, 4'h3, 8'h02}, '{8'hFF, 4'h4, 8'h03},
                          '{8'hFC, 4'hB, 8'h00}};
   scp_regs u_dut (.clk, .rst, .sclk, .serial_select_line_n, .sdi, .sdo, .sdo_oe_n, .pwr, .dp_soft_rst);
   scp_host u_host (.clk, .sdo, .sclk, .serial_select_line_n, .sdi);
   always #50 clk = ~clk;
   always @(negedge clk) if (dp_soft_rst === 1'h1) dp_cnt++;
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic lsb);
      u_host.frame(1'h0, a, lsb, 1, {8'h00, d}, rv);
   endtask : wr
   task automatic rd(input logic [14:0] a, input logic lsb, input logic [7:0] e);
      u_host.frame(1'h1, a, lsb, 1, 16'h0000, rv);
      chk(rv[7:0], e);
   endtask : rd
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   // Boot wait plus about two dozen frames
   initial begin
      #8000000;
      fail_count++;
      test_done;
   end
   initial begin
      repeat (12) @(negedge clk);
      rst <= 1'h0;
      @(negedge clk);
      chk({4'h0, pwr}, 8'h0B);
      chk({7'h00, sdo_oe_n}, 8'h01);
      foreach (rows[i]) begin
         wr(`SCP_ADDR_PWR, rows[i].wd, 1'h0);
         chk({4'h0, pwr}, {4'h0, rows[i].pw});
         rd(`SCP_ADDR_PWR, 1'h0, rows[i].rb);
      end
      wr(`SCP_ADDR_CFG_A, 8'h04, 1'h0);
      u_host.frame(1'h1, `SCP_ADDR_CFG_A, 1'h0, 2, 16'h0000, rv);
      chk(rv[7:0], 8'h04);
      chk(rv[15:8], 8'h00);
      u_host.frame(1'h0, `SCP_ADDR_CFG_B, 1'h0, 2, 16'h0300, rv);
      chk({4'h0, pwr}, 8'h04);
      wr(`SCP_ADDR_CFG_B, 8'h80, 1'h0);
      u_host.frame(1'h0, `SCP_ADDR_CFG_B, 1'h0, 2, 16'h0280, rv);
      chk({4'h0, pwr}, 8'h04);
      rd(`SCP_ADDR_CFG_B, 1'h0, 8'h80);
      dp_cnt = 0;
      wr(`SCP_ADDR_CFG_B, 8'h02, 1'h0);
      chk(dp_cnt[7:0], 8'h01);
      rd(`SCP_ADDR_CFG_B, 1'h0, 8'h00);
      wr(15'h0010, 8'hFF, 1'h0);
      rd(15'h0010, 1'h0, 8'h00);
      wr(`SCP_ADDR_CFG_A, 8'h02, 1'h0);
      wr(`SCP_ADDR_PWR, 8'h02, 1'h1);
      chk({4'h0, pwr}, 8'h03);
      rd(`SCP_ADDR_PWR, 1'h1, 8'h02);
      rd(`SCP_ADDR_CFG_A, 1'h1, 8'h02);
      // Multibyte read with ascension cleared still steps the address
      u_host.frame(1'h1, `SCP_ADDR_CFG_B, 1'h1, 2, 16'h0000, rv);
      chk(rv[7:0], 8'h00);
      chk(rv[15:8], 8'h02);
      wr(`SCP_ADDR_CFG_A, 8'h01, 1'h1);
      repeat (`SCP_BOOT_WAIT_CYC) @(negedge clk);
      chk({4'h0, pwr}, 8'h0B);
      rd(`SCP_ADDR_CFG_A, 1'h0, 8'h00);
      rd(`SCP_ADDR_PWR, 1'h0, 8'h00);
      test_done;
   end
endmodule : testbench
